// File: hw/uirq_defines.svh
`ifndef UIRQ_DEFINES_SVH
`define UIRQ_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define UIRQ_OFS_CTRL 12'h004
`define UIRQ_OFS_ENABLE 12'h010
`define UIRQ_OFS_DISABLE 12'h014
`define UIRQ_OFS_MASK 12'h018
`define UIRQ_OFS_STATUS 12'h01C
`define UIRQ_OFS_CLEAR 12'h020
`define UIRQ_OFS_EPCSR 12'h030
`define UIRQ_OFS_EPCSR_LAST 12'h044

// ==========================================================
// Field positions
`define UIRQ_NUM_EP 6
`define UIRQ_STAT_W 14
`define UIRQ_BIT_SUSP 8
`define UIRQ_BIT_RSM 9
`define UIRQ_BIT_EXT 10
`define UIRQ_BIT_SOF 11
`define UIRQ_BIT_BRE 12
`define UIRQ_BIT_WAKE 13
`define UIRQ_CTRL_RWE 0
`define UIRQ_CTRL_SUSP 1
`define UIRQ_CSR_TXC 0
`define UIRQ_CSR_BK0 1
`define UIRQ_CSR_SETUP 2
`define UIRQ_CSR_STALL 3
`define UIRQ_CSR_BK1 6

// ==========================================================
// Masks and reset values
`define UIRQ_MASK_BITS 14'h2F3F
`define UIRQ_CLR_BITS 14'h3F00
`define UIRQ_NOMASK_BITS 14'h1000
`define UIRQ_MASK_RST 14'h0200
`define UIRQ_STAT_RST 14'h0000

// ==========================================================
// Timing
`define UIRQ_CLK_MHZ 25
`define UIRQ_IDLE_US 3000
`define UIRQ_RESUME_US 10000

`endif

// File: hw/uirq_pkg.sv
package uirq_pkg;
    typedef enum logic [1:0] {
        UIRQ_ACTIVE,
        UIRQ_SUSPENDED,
        UIRQ_RESUMING
    } uirq_link_t;
endpackage : uirq_pkg

// File: hw/uirq_sync.sv
`timescale 1ns/1ps
module uirq_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule : uirq_sync

// File: hw/uirq_top.sv
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "uirq_defines.svh"
// Operation
// - Disable write one clears endpoint mask bit
// - Disable write one clears bus-level mask bit
// - Disable register is write-only, reads zero
// - Mask reports endpoint enables
// - Mask reports bus-level enables; bit 12 is always enabled here but reads zero
// - Resume source enabled out of reset
// - Endpoint status set by any endpoint flag
// - Endpoint status holds until flag cleared
// - Idle timeout sets suspend status, enters suspend
// - Host resume sets resume status
// - Resume pin edge in suspend sets status
// - Remote wake enabled drives resume state
// - Frame start token sets status
// - Bus reset end sets status bit 12
// - Host resume or reset sets wake status
// - Enable write one sets mask bit
// - Clear write one clears bus status bit
// - Writing zero clears transmit complete flag
module uirq_top #(
    parameter int IDLE_CYCLES = `UIRQ_IDLE_US * `UIRQ_CLK_MHZ,
    parameter int RESUME_CYCLES = `UIRQ_RESUME_US * `UIRQ_CLK_MHZ
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Endpoint flags from endpoint logic: levels, except tx_ack_pulse, a pulse
    input wire logic [`UIRQ_NUM_EP-1:0] setup_received,
    input wire logic [`UIRQ_NUM_EP-1:0] bank0_received,
    input wire logic [`UIRQ_NUM_EP-1:0] bank1_received,
    input wire logic [`UIRQ_NUM_EP-1:0] stall_acknowledged,
    input wire logic [`UIRQ_NUM_EP-1:0] tx_ack_pulse,
    // Bus events from port logic
    input wire logic bus_activity,
    input wire logic bus_resume_seen,
    input wire logic sof_token_seen,
    input wire logic bus_reset_seen,
    input wire logic bus_reset_done,
    // Asynchronous resume request pin
    input wire logic resume_request_pin,
    // Port side outputs
    output logic port_irq,
    output logic drive_resume,
    output uirq_pkg::uirq_link_t link_state,
    output logic [`UIRQ_NUM_EP-1:0] transmit_complete
);
    import uirq_pkg::*;

    localparam int NEP = `UIRQ_NUM_EP;
    localparam int SW = `UIRQ_STAT_W;

    // ==========================================================
    // APB decode
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    wire access = psel && penable;
    wire done = access && pready_ff;
    wire wr = done && pwrite;
    wire sel_ctrl = paddr == `UIRQ_OFS_CTRL;
    wire sel_en = paddr == `UIRQ_OFS_ENABLE;
    wire sel_dis = paddr == `UIRQ_OFS_DISABLE;
    wire sel_mask = paddr == `UIRQ_OFS_MASK;
    wire sel_stat = paddr == `UIRQ_OFS_STATUS;
    wire sel_clr = paddr == `UIRQ_OFS_CLEAR;
    wire sel_csr = paddr >= `UIRQ_OFS_EPCSR && paddr <= `UIRQ_OFS_EPCSR_LAST
        && paddr[1:0] == 2'h0;
    wire [2:0] csr_idx = 3'((paddr - `UIRQ_OFS_EPCSR) >> 2);
    wire mapped = sel_ctrl || sel_en || sel_dis || sel_mask || sel_stat
        || sel_clr || sel_csr;
    wire [SW-1:0] wbits = pwdata[SW-1:0];
    wire wr_en = wr && sel_en;
    wire wr_dis = wr && sel_dis;
    wire wr_clr = wr && sel_clr;
    wire wr_ctrl = wr && sel_ctrl;
    wire wr_csr = wr && sel_csr;

    // ==========================================================
    // Resume pin: synchronised before edge detection
    logic ext_sync;
    logic ext_prev_ff;
    uirq_sync #(.W(1)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(resume_request_pin),
        .q(ext_sync)
    );
    wire ext_edge = ext_sync && !ext_prev_ff;

    // ==========================================================
    // Link state: idle timer, suspend, remote wake
    uirq_link_t state_ff;
    uirq_link_t nxt_state;
    logic [31:0] idle_cnt_ff;
    logic [31:0] nxt_idle_cnt;
    logic rwe_ff;
    logic drive_ff;
    wire suspended = state_ff == UIRQ_SUSPENDED;
    wire idle_hit = state_ff == UIRQ_ACTIVE && !bus_activity
        && idle_cnt_ff == 32'(IDLE_CYCLES - 1);
    wire ext_evt = suspended && ext_edge;
    wire rsm_hit = state_ff == UIRQ_RESUMING
        && idle_cnt_ff == 32'(RESUME_CYCLES - 1);

    always_comb begin
        nxt_state = state_ff;
        nxt_idle_cnt = idle_cnt_ff + 32'h1;
        case (state_ff)
            UIRQ_ACTIVE: begin
                if (bus_activity) begin
                    nxt_idle_cnt = 32'h0;
                end else if (idle_hit) begin
                    nxt_state = UIRQ_SUSPENDED;
                    nxt_idle_cnt = 32'h0;
                end
            end
            UIRQ_SUSPENDED: begin
                nxt_idle_cnt = 32'h0;
                if (ext_evt && rwe_ff) begin
                    nxt_state = UIRQ_RESUMING;
                end else if (bus_activity || bus_resume_seen) begin
                    nxt_state = UIRQ_ACTIVE;
                end
            end
            UIRQ_RESUMING: begin
                if (rsm_hit) begin
                    nxt_state = UIRQ_ACTIVE;
                    nxt_idle_cnt = 32'h0;
                end
            end
            default: begin
                nxt_state = UIRQ_ACTIVE;
                nxt_idle_cnt = 32'h0;
            end
        endcase
    end

    wire nxt_drive = nxt_state == UIRQ_RESUMING;

    // ==========================================================
    // Transmit complete flags, one per endpoint
    logic [NEP-1:0] txc_ff;
    logic [NEP-1:0] nxt_txc;
    logic [NEP-1:0] ep_any;
    logic [31:0] csr_rd [NEP];
    genvar i;
    generate
        for (i = 0; i < NEP; i++) begin : g_ep
            // Set wins over a clearing write in the same cycle
            assign nxt_txc[i] = tx_ack_pulse[i] || (txc_ff[i]
                && !(wr_csr && csr_idx == 3'(i)
                && !pwdata[`UIRQ_CSR_TXC]));
            // Level OR: bit drops only once every cause is cleared
            assign ep_any[i] = txc_ff[i] || bank0_received[i]
                || bank1_received[i] || setup_received[i]
                || stall_acknowledged[i];
            always_comb begin
                csr_rd[i] = 32'h0;
                csr_rd[i][`UIRQ_CSR_TXC] = txc_ff[i];
                csr_rd[i][`UIRQ_CSR_BK0] = bank0_received[i];
                csr_rd[i][`UIRQ_CSR_SETUP] = setup_received[i];
                csr_rd[i][`UIRQ_CSR_STALL] = stall_acknowledged[i];
                csr_rd[i][`UIRQ_CSR_BK1] = bank1_received[i];
            end
        end
    endgenerate

    // ==========================================================
    // Mask and status
    logic [SW-1:0] mask_ff;
    logic [SW-1:0] stat_ff;
    logic irq_ff;
    wire [SW-1:0] nxt_mask = wr_en ? mask_ff | (wbits & `UIRQ_MASK_BITS)
        : wr_dis ? mask_ff & ~(wbits & `UIRQ_MASK_BITS)
        : mask_ff;
    wire [SW-1:0] bus_set = SW'({bus_resume_seen || bus_reset_seen,
        bus_reset_done, sof_token_seen, ext_evt, bus_resume_seen,
        idle_hit}) << `UIRQ_BIT_SUSP;
    // Bits 8 to 13
    wire [SW-1:0] bus_clr = wr_clr ? wbits & `UIRQ_CLR_BITS : '0;
    wire [SW-1:0] bus_keep = stat_ff & `UIRQ_CLR_BITS & ~bus_clr;
    wire [SW-1:0] nxt_stat = (bus_keep | bus_set) | SW'(ep_any);
    // set wins over clear
    wire [SW-1:0] mask_eff = mask_ff | `UIRQ_NOMASK_BITS;
    wire nxt_irq = |(stat_ff & mask_eff);

    // ==========================================================
    // Read mux; disable, enable and clear read back zero
    wire [31:0] ctrl_rd = (32'(rwe_ff) << `UIRQ_CTRL_RWE)
        | (32'(suspended) << `UIRQ_CTRL_SUSP);
    wire [31:0] rd_data = sel_mask ? 32'(mask_ff)
        : sel_stat ? 32'(stat_ff)
        : sel_ctrl ? ctrl_rd
        : sel_csr ? csr_rd[csr_idx]
        : 32'h0;
    wire nxt_pready = access && !pready_ff;
    wire nxt_rwe = wr_ctrl ? pwdata[`UIRQ_CTRL_RWE] : rwe_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pready && !mapped;
            prdata_ff <= nxt_pready && !pwrite ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= `UIRQ_MASK_RST;
            stat_ff <= `UIRQ_STAT_RST;
            irq_ff <= 1'b0;
            txc_ff <= '0;
            rwe_ff <= 1'b0;
        end else begin
            mask_ff <= nxt_mask;
            stat_ff <= nxt_stat;
            irq_ff <= nxt_irq;
            txc_ff <= nxt_txc;
            rwe_ff <= nxt_rwe;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= UIRQ_ACTIVE;
            idle_cnt_ff <= 32'h0;
            drive_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            idle_cnt_ff <= nxt_idle_cnt;
            drive_ff <= nxt_drive;
            ext_prev_ff <= ext_sync;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign port_irq = irq_ff;
    assign drive_resume = drive_ff;
    assign link_state = state_ff;
    assign transmit_complete = txc_ff;

    // ==========================================================
    // Assertions
    a_disable_clears_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_dis |=> (mask_ff & $past(wbits)) == '0)
        else $error("disable write left a mask bit set");
    a_enable_sets_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en |=> (~mask_ff & $past(wbits) & `UIRQ_MASK_BITS) == '0)
        else $error("enable write did not set mask bit");
    a_mask_read_back: assert property (
        @(posedge pclk) disable iff (!presetn)
        (nxt_pready && !pwrite && sel_mask)
        |=> prdata == 32'($past(mask_ff)))
        else $error("mask read returned wrong value");
    a_disable_reads_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (nxt_pready && !pwrite && sel_dis) |=> prdata == 32'h0)
        else $error("disable register read not zero");
    a_ep_status_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 stat_ff[NEP-1:0] == $past(ep_any))
        else $error("endpoint status not following flags");
    a_suspend_timeout: assert property (
        @(posedge pclk) disable iff (!presetn)
        idle_hit |=> stat_ff[`UIRQ_BIT_SUSP] && suspended)
        else $error("idle timeout did not suspend");
    a_host_resume_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        bus_resume_seen |=> stat_ff[`UIRQ_BIT_RSM]
        && stat_ff[`UIRQ_BIT_WAKE])
        else $error("host resume not recorded");
    a_remote_wake_drive: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ext_evt && rwe_ff) |=> drive_resume
        && stat_ff[`UIRQ_BIT_EXT] ##1 drive_resume)
        else $error("remote wake did not drive resume");
    a_clear_status: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_clr && pwdata[`UIRQ_BIT_SOF] && !sof_token_seen)
        |=> !stat_ff[`UIRQ_BIT_SOF])
        else $error("clear write did not clear frame status");
    a_irq_output: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 port_irq == $past(|(stat_ff & mask_eff)))
        else $error("interrupt output mismatch");
endmodule : uirq_top

// File: verification/uirq_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host side of the port: one-cycle events on request
module uirq_host_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench requests: sof, resume, reset, reset end
    input wire logic [3:0] ev_req,
    input wire logic idle_req,
    // Port events
    output logic bus_activity,
    output logic sof_token_seen,
    output logic bus_resume_seen,
    output logic bus_reset_seen,
    output logic bus_reset_done
);
    // Registered so every event is clean and exactly as wide as its request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_activity <= 1'b1;
            sof_token_seen <= 1'b0;
            bus_resume_seen <= 1'b0;
            bus_reset_seen <= 1'b0;
            bus_reset_done <= 1'b0;
        end else begin
            bus_activity <= !idle_req;
            sof_token_seen <= ev_req[0];
            bus_resume_seen <= ev_req[1];
            bus_reset_seen <= ev_req[2];
            bus_reset_done <= ev_req[3];
        end
    end
endmodule : uirq_host_model

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "uirq_defines.svh"
module testbench;
    import uirq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, port_irq, drive_resume;
    logic [5:0] fl [5] = '{default: 6'h00};
    logic [3:0] ev_req = 4'h0;
    logic idle_req = 1'b0;
    logic resume_request_pin = 1'b0;
    logic bus_activity, sof_token_seen, bus_resume_seen;
    logic bus_reset_seen, bus_reset_done;
    uirq_link_t link_state;
    logic [5:0] transmit_complete;
    logic [32:0] exp_q [$];
    logic [32:0] e;
    logic [31:0] mexp, r;
    logic [13:0] ev_exp [4] = '{14'h0800, 14'h2200, 14'h2000, 14'h1000};
    // Endpoint register image per flag kind, in the order of fl
    logic [31:0] csr_exp [5] = '{32'h4, 32'h2, 32'h40, 32'h8, 32'h1};
    int err_total = 0;
    int cmp_count = 0;
    int seed = 77252;
    int ep;

    always #20 pclk = ~pclk;

    uirq_host_model u_host (.pclk(pclk), .presetn(presetn),
        .ev_req(ev_req), .idle_req(idle_req),
        .bus_activity(bus_activity), .sof_token_seen(sof_token_seen),
        .bus_resume_seen(bus_resume_seen),
        .bus_reset_seen(bus_reset_seen), .bus_reset_done(bus_reset_done));

    // Short idle and resume counts keep the run brief
    uirq_top #(.IDLE_CYCLES(20), .RESUME_CYCLES(10)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .setup_received(fl[0]), .bank0_received(fl[1]),
        .bank1_received(fl[2]), .stall_acknowledged(fl[3]),
        .tx_ack_pulse(fl[4]), .bus_activity(bus_activity),
        .bus_resume_seen(bus_resume_seen),
        .sof_token_seen(sof_token_seen), .bus_reset_seen(bus_reset_seen),
        .bus_reset_done(bus_reset_done),
        .resume_request_pin(resume_request_pin), .port_irq(port_irq),
        .drive_resume(drive_resume), .link_state(link_state),
        .transmit_complete(transmit_complete));

    // ==========================================
    // Helpers
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task finish_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] exp, input logic er);
        int n;
        exp_q.push_back({er, exp});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Only the watchdog bounds this wait
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("wait states", 32'h2, 32'(n));
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next setup never overwrites this release
        @(posedge pclk);
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask : rd

    task ev(input int j);
        ev_req[j] <= 1'b1;
        @(posedge pclk);
        ev_req <= 4'h0;
        repeat (4) @(posedge pclk);
    endtask : ev

    // ==========================================
    // Answer watcher
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("spare answer", 32'h0, 32'h1);
            end else begin
                e = exp_q.pop_front();
                chk("read data", e[31:0], prdata);
                chk("slave error", {31'h0, e[32]}, {31'h0, pslverr});
            end
        end
    end

    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        finish_test;
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`UIRQ_OFS_MASK, 32'h0000_0200);
        rd(`UIRQ_OFS_STATUS, 32'h0);
        wr(`UIRQ_OFS_CLEAR, 32'h0000_3F00);
        wr(`UIRQ_OFS_ENABLE, 32'hFFFF_FFFF);
        mexp = 32'h0000_2F3F;
        rd(`UIRQ_OFS_MASK, mexp);
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            wr(`UIRQ_OFS_DISABLE, r);
            mexp = mexp & ~r;
            rd(`UIRQ_OFS_MASK, mexp);
            rd(`UIRQ_OFS_DISABLE, 32'h0);
        end
        wr(`UIRQ_OFS_MASK, 32'h0);
        rd(`UIRQ_OFS_MASK, mexp);
        wr(`UIRQ_OFS_ENABLE, 32'h0000_2F3F);
        rd(`UIRQ_OFS_MASK, 32'h0000_2F3F);
        apb(1'b0, 12'hFF0, 32'h0, 32'h0, 1'b1);
        for (int j = 0; j < 4; j++) begin
            ev(j);
            chk("port irq", 32'h1, {31'h0, port_irq});
            rd(`UIRQ_OFS_STATUS, {18'h0, ev_exp[j]});
            wr(`UIRQ_OFS_CLEAR, 32'h0000_3F00);
            rd(`UIRQ_OFS_STATUS, 32'h0);
        end
        wr(`UIRQ_OFS_DISABLE, 32'h0000_0800);
        ev(0);
        chk("port irq", 32'h0, {31'h0, port_irq});
        rd(`UIRQ_OFS_STATUS, 32'h0000_0800);
        wr(`UIRQ_OFS_CLEAR, 32'h0000_3F00);
        for (int i = 0; i < 5; i++) begin
            ep = $unsigned($random(seed)) % 6;
            fl[i][ep] <= 1'b1;
            @(posedge pclk);
            if (i == 4) fl[4][ep] <= 1'b0;
            repeat (4) @(posedge pclk);
            rd(`UIRQ_OFS_STATUS, 32'h1 << ep);
            chk("port irq", 32'h1, {31'h0, port_irq});
            repeat (6) @(posedge pclk);
            rd(`UIRQ_OFS_STATUS, 32'h1 << ep);
            rd(`UIRQ_OFS_EPCSR + 12'(4 * ep), csr_exp[i]);
            if (i == 4) begin
                chk("tx done", 32'h1 << ep, {26'h0, transmit_complete});
                wr(`UIRQ_OFS_EPCSR + 12'(4 * ep), 32'h0);
            end else begin
                fl[i][ep] <= 1'b0;
            end
            repeat (3) @(posedge pclk);
            rd(`UIRQ_OFS_STATUS, 32'h0);
        end
        wr(`UIRQ_OFS_CTRL, 32'h1);
        idle_req <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("link", 32'(UIRQ_SUSPENDED), 32'(link_state));
        rd(`UIRQ_OFS_STATUS, 32'h0000_0100);
        rd(`UIRQ_OFS_CTRL, 32'h3);
        resume_request_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("drive resume", 32'h1, {31'h0, drive_resume});
        rd(`UIRQ_OFS_STATUS, 32'h0000_0500);
        idle_req <= 1'b0;
        resume_request_pin <= 1'b0;
        repeat (30) @(posedge pclk);
        wr(`UIRQ_OFS_CLEAR, 32'h0000_3F00);
        resume_request_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(`UIRQ_OFS_STATUS, 32'h0);
        // Remote wake off: external resume is recorded, bus not driven
        wr(`UIRQ_OFS_CTRL, 32'h0);
        resume_request_pin <= 1'b0;
        idle_req <= 1'b1;
        repeat (30) @(posedge pclk);
        rd(`UIRQ_OFS_CTRL, 32'h2);
        resume_request_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("drive resume", 32'h0, {31'h0, drive_resume});
        rd(`UIRQ_OFS_STATUS, 32'h0000_0500);
        finish_test;
    end
endmodule : testbench
